// ==== verilog/lrs_rail_ctrl.sv ====
`timescale 1ns/1ps
`include "lrs_params.svh"

// Functional notes
// R1 - An 8-bit read/write analog rail control register sits at 0x40 and resets to 0x3C.
// R2 - An 8-bit read/write 1.8 V rail control register sits at 0x43 and resets to 0x3C.
// R3 - Bits 2:0 set the rail state: code 4 off, 5 low power, 6 and 7 active, 0 to 3 reserved.
// R4 - Bits 5:3 hold a standby-exit state that is applied to the rail when the exit pin asserts.
// R5 - On standby exit, exit codes 0 to 3 leave the state alone and 4, 5, 6-7 copy off, low, active.
// R6 - The host writes the standby-exit fields after power-up before relying on standby exit.
// R7 - Each rail is controlled only by its own register though the supply pins are shared.
// R8 - Over-current and under-voltage events of each rail are flagged as readable status.
// R9 - The analog rail output is actively discharged whenever that rail is shut down.
// R10 - The 1.8 V rail output is actively discharged whenever that rail is shut down.
// R11 - The measured output current of the 1.8 V rail is passed on to the converter subsystem; the code passes it only while the rail is not off, else 0.
// R12 - Bits 7:6 of each rail register read as zero and ignore writes.
module lrs_rail_ctrl (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire lrs_pkg::lrs_reg_req_t reg_req,
   output lrs_pkg::lrs_reg_rsp_t reg_rsp,
   input wire logic standby_exit_pin,
   input wire logic [1:0] rail_oc_raw,
   input wire logic [1:0] rail_uv_raw,
   input wire logic [9:0] core_1v8_imon_raw,
   output lrs_pkg::lrs_rail_out_t analog_rail_out,
   output lrs_pkg::lrs_rail_out_t core_1v8_rail_out,
   output logic [9:0] core_1v8_imon_adc,
   output logic core_1v8_imon_valid
);
   import lrs_pkg::*;

   // ****************************************
   // Reset release
   // ****************************************
   logic rst_sync_a;
   logic rst_sync_b;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_a <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_sync_a <= 1'b1;
         rst_sync_b <= rst_sync_a;
      end
   end

   wire logic sys_rst_n = rst_sync_b;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic exit_meta;
   logic exit_sync;
   logic exit_prev;
   logic [1:0] oc_meta;
   logic [1:0] oc_sync;
   logic [1:0] uv_meta;
   logic [1:0] uv_sync;
   logic [9:0] imon_meta;
   logic [9:0] imon_sync;

   always_ff @(posedge core_clk or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         exit_meta <= 1'b0;
         exit_sync <= 1'b0;
         exit_prev <= 1'b0;
         oc_meta <= 2'h0;
         oc_sync <= 2'h0;
         uv_meta <= 2'h0;
         uv_sync <= 2'h0;
         imon_meta <= 10'h000;
         imon_sync <= 10'h000;
      end else begin
         exit_meta <= standby_exit_pin;
         exit_sync <= exit_meta;
         exit_prev <= exit_sync;
         oc_meta <= rail_oc_raw;
         oc_sync <= oc_meta;
         uv_meta <= rail_uv_raw;
         uv_sync <= uv_meta;
         imon_meta <= core_1v8_imon_raw;
         imon_sync <= imon_meta;
      end
   end

   // Exit takes effect once per assertion
   wire logic exit_event = exit_sync & ~exit_prev; // [R4]

   // ****************************************
   // Rail control registers
   // ****************************************
   logic [7:0] rail_ctrl [LRS_NUM_RAILS];
   lrs_mode_t rail_mode [LRS_NUM_RAILS];
   logic [7:0] rail_offset [LRS_NUM_RAILS];

   assign rail_offset[0] = `LRS_ANALOG_RAIL_CONTROL_OFFSET; // [R1]
   assign rail_offset[1] = `LRS_CORE_1V8_RAIL_CONTROL_OFFSET; // [R2]

   function automatic lrs_mode_t decode_mode(input logic [2:0] code, input lrs_mode_t held);
      lrs_mode_t m;
      m = held;
      if (code == `LRS_CODE_OFF) begin
         m = LRS_MODE_OFF;
      end else if (code == `LRS_CODE_LOW_POWER) begin
         m = LRS_MODE_LOW_POWER;
      end else if (code == `LRS_CODE_ACTIVE_A || code == `LRS_CODE_ACTIVE_B) begin
         m = LRS_MODE_ACTIVE;
      end
      return m;
   endfunction : decode_mode

   genvar gi;
   generate
      for (gi = 0; gi < LRS_NUM_RAILS; gi++) begin : g_rail
         logic [7:0] next_ctrl;
         logic [2:0] exit_code;

         assign exit_code = next_ctrl[`LRS_EXIT_MSB:`LRS_EXIT_LSB];

         always_comb begin
            next_ctrl = rail_ctrl[gi];
            if (reg_req.wr && reg_req.addr == rail_offset[gi]) begin // [R7]
               next_ctrl = {2'b00, reg_req.wdata[`LRS_EXIT_MSB:`LRS_STATE_LSB]}; // [R12]
            end
            if (exit_event && exit_code[2]) begin // [R5]
               next_ctrl[`LRS_STATE_MSB:`LRS_STATE_LSB] = exit_code; // [R4]
            end
         end

         always_ff @(posedge core_clk or negedge sys_rst_n) begin
            if (!sys_rst_n) begin
               rail_ctrl[gi] <= `LRS_RAIL_CONTROL_RESET; // [R1] [R2]
            end else begin
               rail_ctrl[gi] <= next_ctrl;
            end
         end

         // Reserved state codes keep the last valid mode
         always_ff @(posedge core_clk or negedge sys_rst_n) begin
            if (!sys_rst_n) begin
               rail_mode[gi] <= LRS_MODE_OFF;
            end else begin
               rail_mode[gi] <= decode_mode(rail_ctrl[gi][`LRS_STATE_MSB:`LRS_STATE_LSB],
                                            rail_mode[gi]); // [R3]
            end
         end
      end
   endgenerate

   // ****************************************
   // Rail outputs
   // ****************************************
   always_ff @(posedge core_clk or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         analog_rail_out <= '{mode: LRS_MODE_OFF, enable: 1'b0, discharge_en: 1'b1};
         core_1v8_rail_out <= '{mode: LRS_MODE_OFF, enable: 1'b0, discharge_en: 1'b1};
      end else begin
         analog_rail_out.mode <= rail_mode[0];
         analog_rail_out.enable <= (rail_mode[0] != LRS_MODE_OFF);
         analog_rail_out.discharge_en <= (rail_mode[0] == LRS_MODE_OFF); // [R9]
         core_1v8_rail_out.mode <= rail_mode[1];
         core_1v8_rail_out.enable <= (rail_mode[1] != LRS_MODE_OFF);
         core_1v8_rail_out.discharge_en <= (rail_mode[1] == LRS_MODE_OFF); // [R10]
      end
   end

   // ****************************************
   // Current monitor hand-off
   // ****************************************
   always_ff @(posedge core_clk or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         core_1v8_imon_adc <= 10'h000;
         core_1v8_imon_valid <= 1'b0;
      end else begin
         core_1v8_imon_valid <= (rail_mode[1] != LRS_MODE_OFF); // [R11]
         core_1v8_imon_adc <= (rail_mode[1] != LRS_MODE_OFF) ? imon_sync : 10'h000; // [R11]
      end
   end

   // ****************************************
   // Fault status
   // ****************************************
   logic [1:0] oc_flag;
   logic [1:0] uv_flag;
   wire logic status_wr = reg_req.wr && reg_req.addr == `LRS_RAIL_STATUS_OFFSET;

   // Set wins over a write-one clear in the same cycle
   always_ff @(posedge core_clk or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         oc_flag <= 2'h0;
         uv_flag <= 2'h0;
      end else begin
         oc_flag <= (oc_flag & ~(status_wr ? reg_req.wdata[1:0] : 2'h0)) | oc_sync; // [R8]
         uv_flag <= (uv_flag & ~(status_wr ? reg_req.wdata[5:4] : 2'h0)) | uv_sync; // [R8]
      end
   end

   // ****************************************
   // Register read
   // ****************************************
   logic [7:0] next_rdata;

   always_comb begin
      if (reg_req.addr == rail_offset[0]) begin
         next_rdata = rail_ctrl[0];
      end else if (reg_req.addr == rail_offset[1]) begin
         next_rdata = rail_ctrl[1];
      end else if (reg_req.addr == `LRS_RAIL_STATUS_OFFSET) begin
         next_rdata = {2'b00, uv_flag, 2'b00, oc_flag}; // [R8]
      end else begin
         next_rdata = `LRS_READ_UNMAPPED;
      end
   end

   always_ff @(posedge core_clk or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         reg_rsp <= '{valid: 1'b0, rdata: 8'h00};
      end else begin
         reg_rsp.valid <= reg_req.rd;
         reg_rsp.rdata <= reg_req.rd ? next_rdata : 8'h00;
      end
   end

endmodule : lrs_rail_ctrl

// ==== verilog/lrs_params.svh ====
`ifndef LRS_PARAMS_SVH
`define LRS_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define LRS_ANALOG_RAIL_CONTROL_OFFSET 8'h40
`define LRS_CORE_1V8_RAIL_CONTROL_OFFSET 8'h43
`define LRS_RAIL_STATUS_OFFSET 8'h4A

// ****************************************
// Reset values
// ****************************************
`define LRS_RAIL_CONTROL_RESET 8'h3C
`define LRS_RAIL_STATUS_RESET 8'h00
`define LRS_READ_UNMAPPED 8'h00

// ****************************************
// Field positions
// ****************************************
`define LRS_STATE_LSB 0
`define LRS_STATE_MSB 2
`define LRS_EXIT_LSB 3
`define LRS_EXIT_MSB 5
`define LRS_RSVD_LSB 6
`define LRS_RSVD_MSB 7
`define LRS_STATUS_OC_LSB 0
`define LRS_STATUS_UV_LSB 4

// ****************************************
// Field codes
// ****************************************
`define LRS_CODE_OFF 3'h4
`define LRS_CODE_LOW_POWER 3'h5
`define LRS_CODE_ACTIVE_A 3'h6
`define LRS_CODE_ACTIVE_B 3'h7

`endif

// ==== verilog/lrs_pkg.sv ====
package lrs_pkg;

   localparam int unsigned LRS_NUM_RAILS = 2;

   typedef enum logic [2:0] {
      LRS_MODE_OFF = 3'b001,
      LRS_MODE_LOW_POWER = 3'b010,
      LRS_MODE_ACTIVE = 3'b100
   } lrs_mode_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } lrs_reg_req_t;

   typedef struct packed {
      logic valid;
      logic [7:0] rdata;
   } lrs_reg_rsp_t;

   typedef struct packed {
      lrs_mode_t mode;
      logic enable;
      logic discharge_en;
   } lrs_rail_out_t;

endpackage : lrs_pkg

// ==== verif/lrs_rail_ctrl_props.sv ====
`timescale 1ns/1ps
// ***
// Port checks
// ***
module lrs_rail_ctrl_props (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire lrs_pkg::lrs_reg_req_t reg_req,
   input wire lrs_pkg::lrs_reg_rsp_t reg_rsp,
   input wire lrs_pkg::lrs_rail_out_t analog_rail_out,
   input wire lrs_pkg::lrs_rail_out_t core_1v8_rail_out,
   input wire logic [9:0] core_1v8_imon_adc,
   input wire logic core_1v8_imon_valid
);
   import lrs_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   property p_rd_rsp; reg_req.rd |=> reg_rsp.valid; endproperty
   a_rd_rsp: assert property (p_rd_rsp) else $error("read not answered");
   property p_no_rsp; !reg_req.rd |=> !reg_rsp.valid; endproperty
   a_no_rsp: assert property (p_no_rsp) else $error("stray response");
   property p_rsvd; reg_rsp.valid |-> reg_rsp.rdata[7:6] == 2'h0; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
   property p_dis_a;
      analog_rail_out.discharge_en == (analog_rail_out.mode == LRS_MODE_OFF);
   endproperty
   a_dis_a: assert property (p_dis_a) else $error("analog discharge wrong");
   property p_dis_c;
      core_1v8_rail_out.discharge_en == (core_1v8_rail_out.mode == LRS_MODE_OFF);
   endproperty
   a_dis_c: assert property (p_dis_c) else $error("core discharge wrong");
   property p_wr_off;
      reg_req.wr && reg_req.addr == 8'h40 && reg_req.wdata[2:0] == 3'h4
         |-> ##3 analog_rail_out.mode == LRS_MODE_OFF;
   endproperty
   a_wr_off: assert property (p_wr_off) else $error("off not applied");
   property p_wr_lp;
      reg_req.wr && reg_req.addr == 8'h43 && reg_req.wdata[2:0] == 3'h5
         |-> ##3 core_1v8_rail_out.mode == LRS_MODE_LOW_POWER;
   endproperty
   a_wr_lp: assert property (p_wr_lp) else $error("low power not applied");
   property p_imon; !core_1v8_imon_valid |-> core_1v8_imon_adc == 10'h000; endproperty
   a_imon: assert property (p_imon) else $error("current passed while off");
endmodule : lrs_rail_ctrl_props

bind lrs_rail_ctrl lrs_rail_ctrl_props lrs_rail_ctrl_props_inst (.core_clk, .rst_n, .reg_req,
   .reg_rsp, .analog_rail_out, .core_1v8_rail_out, .core_1v8_imon_adc, .core_1v8_imon_valid);

// ==== verif/lrs_host_model.sv ====
`timescale 1ns/1ps
// ***
// Parallel host register access, one bus cycle per access
// ***
module lrs_host_model (
   input wire logic core_clk,
   output lrs_pkg::lrs_reg_req_t reg_req,
   input wire lrs_pkg::lrs_reg_rsp_t reg_rsp
);
   import lrs_pkg::*;
   initial reg_req = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] dat);
      reg_req = {2'b10, a, dat};
      @(posedge core_clk);
      #1;
      // Released lines show inverted data
      reg_req = {2'b00, ~a, ~dat};
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] dat, output logic vld);
      reg_req = {2'b01, a, reg_req.wdata};
      @(posedge core_clk);
      #1;
      reg_req = {2'b00, ~a, reg_req.wdata};
      dat = reg_rsp.rdata;
      vld = reg_rsp.valid;
   endtask : rd
endmodule : lrs_host_model

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   import lrs_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic standby_exit_pin = 1'b0;
   logic [1:0] rail_oc_raw = 2'h0;
   logic [1:0] rail_uv_raw = 2'h0;
   logic [9:0] core_1v8_imon_raw = 10'h155;
   lrs_reg_req_t reg_req;
   lrs_reg_rsp_t reg_rsp;
   lrs_rail_out_t analog_rail_out;
   lrs_rail_out_t core_1v8_rail_out;
   logic [9:0] core_1v8_imon_adc;
   logic core_1v8_imon_valid;
   logic [7:0] d;
   logic v;
   int error_cnt = 0;
   int n_checks = 0;
   // Address, write data, read back, analog mode, core mode
   logic [29:0] rows [8] = '{{8'h40, 8'hFC, 8'h3C, 3'h1, 3'h1}, {8'h40, 8'h06, 8'h06, 3'h4, 3'h1},
      {8'h40, 8'h05, 8'h05, 3'h2, 3'h1}, {8'h40, 8'h07, 8'h07, 3'h4, 3'h1},
      {8'h40, 8'h01, 8'h01, 3'h4, 3'h1}, {8'h43, 8'h2D, 8'h2D, 3'h4, 3'h2},
      {8'h43, 8'hC4, 8'h04, 3'h4, 3'h1}, {8'h41, 8'hFF, 8'h00, 3'h4, 3'h1}};
   always #50 core_clk = ~core_clk;
   lrs_rail_ctrl lrs_rail_ctrl_inst (.core_clk, .rst_n, .reg_req, .reg_rsp, .standby_exit_pin,
      .rail_oc_raw, .rail_uv_raw, .core_1v8_imon_raw, .analog_rail_out, .core_1v8_rail_out,
      .core_1v8_imon_adc, .core_1v8_imon_valid);
   lrs_host_model lrs_host_model_inst (.core_clk, .reg_req, .reg_rsp);
   task chk(input logic [9:0] seen, input logic [9:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cyc
   task rchk(input logic [7:0] a, input logic [7:0] e);
      lrs_host_model_inst.rd(a, d, v);
      chk(v, 1'b1);
      chk(d, e);
   endtask : rchk
   task pulse;
      standby_exit_pin = 1'b1;
      cyc(8);
      standby_exit_pin = 1'b0;
      cyc(4);
   endtask : pulse
   task complete_run;
      $display("errors=%0d checks=%0d", error_cnt, n_checks);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run
   initial begin
      cyc(16);
      rst_n = 1'b1;
      cyc(3);
      rchk(8'h40, 8'h3C);
      rchk(8'h43, 8'h3C);
      chk(analog_rail_out.discharge_en, 1'b1);
      chk(core_1v8_rail_out.discharge_en, 1'b1);
      foreach (rows[i]) begin
         lrs_host_model_inst.wr(rows[i][29:22], rows[i][21:14]);
         rchk(rows[i][29:22], rows[i][13:6]);
         cyc(3);
         chk(analog_rail_out.mode, rows[i][5:3]);
         chk(core_1v8_rail_out.mode, rows[i][2:0]);
      end
      lrs_host_model_inst.wr(8'h40, 8'h2E);
      lrs_host_model_inst.wr(8'h43, 8'h34);
      pulse();
      rchk(8'h40, 8'h2D);
      rchk(8'h43, 8'h36);
      chk(analog_rail_out.mode, 3'h2);
      chk(core_1v8_rail_out.mode, 3'h4);
      chk(core_1v8_imon_adc, 10'h155);
      chk(core_1v8_imon_valid, 1'b1);
      chk(analog_rail_out.enable, 1'b1);
      chk(core_1v8_rail_out.enable, 1'b1);
      lrs_host_model_inst.wr(8'h40, 8'h1E);
      lrs_host_model_inst.wr(8'h43, 8'h26);
      pulse();
      rchk(8'h40, 8'h1E);
      rchk(8'h43, 8'h24);
      chk(core_1v8_rail_out.discharge_en, 1'b1);
      chk(analog_rail_out.discharge_en, 1'b0);
      chk(core_1v8_rail_out.enable, 1'b0);
      chk(core_1v8_imon_valid, 1'b0);
      chk(core_1v8_imon_adc, 10'h000);
      rail_oc_raw = 2'h1;
      rail_uv_raw = 2'h2;
      cyc(5);
      rail_oc_raw = 2'h0;
      rail_uv_raw = 2'h0;
      cyc(3);
      rchk(8'h4A, 8'h21);
      lrs_host_model_inst.wr(8'h4A, 8'h21);
      rchk(8'h4A, 8'h00);
      rst_n = 1'b0;
      cyc(2);
      rst_n = 1'b1;
      cyc(3);
      rchk(8'h40, 8'h3C);
      complete_run();
   end
   initial begin
      #100000;
      error_cnt++;
      complete_run();
   end
endmodule : testbench
